// file: pin_load_model.sv
// pin load model: pull-downs on pwm pins, pull-ups and a far device on serial pins
`timescale 1ns/1ps
`default_nettype none
module pin_load_model
(
   // pad drive from the block
   input  wire pwm_dac_pkg::pwm_pad_s    pwm_pad,
   input  wire pwm_dac_pkg::serial_pad_s serial_pad,
   // far device drive on the serial pins
   input  wire logic [3:0]               ext_oe,
   input  wire logic [3:0]               ext_o,
   // resolved levels
   output logic [8:0]                    pin_level,
   output logic [3:0]                    serial_level
);
   import pwm_dac_pkg::*;
   // undriven pwm pins fall to the pull-down level
   assign pin_level = pwm_pad.oe & pwm_pad.o;
   // contention at differing levels shows as unknown; a double drive at one level resolves to that level
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         if (serial_pad.oe[k] && ext_oe[k])
            serial_level[k] = (serial_pad.o[k] == ext_o[k]) ? ext_o[k] : 1'bx;
         else if (serial_pad.oe[k])
            serial_level[k] = serial_pad.o[k];
         else if (ext_oe[k])
            serial_level[k] = ext_o[k];
         else
            serial_level[k] = 1'b1;
      end
   end
endmodule : pin_load_model
`default_nettype wire

// file: pwm_dac_channel.sv
// one pwm dac channel: shadowed pulse width, scaled by shift and compared against the phase
`timescale 1ns/1ps
`default_nettype none
module pwm_dac_channel
   import pwm_dac_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // period timing
   input  wire logic        start,
   input  wire logic        last,
   input  wire logic [23:0] phase,
   input  wire logic [3:0]  shift,
   input  wire logic        reduced,
   // setting and output
   input  wire logic [7:0]  value,
   output logic             pwm
);
   logic [7:0]  val_q;
   logic        pwm_q;
   logic [23:0] scaled;
   logic        force_low;
   logic        force_high;
   logic        pwm_d;

   assign scaled     = {16'h0000, val_q} << shift;
   // a full scale value still drops low in the final phase of a 256-step period
   assign force_low  = (val_q == 8'h00) || (last && !reduced);
   assign force_high = reduced && (val_q >= HIGH_FLOOR);
   assign pwm_d      = force_high ? 1'b1 : (force_low ? 1'b0 : (phase < scaled));
   assign pwm        = pwm_q;

   // new setting taken only at a period boundary so no pulse is cut short
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         val_q <= RST_PULSE_WIDTH;
         pwm_q <= 1'b0;
      end else begin
         if (start) begin
            val_q <= value;
         end
         pwm_q <= pwm_d;
      end
   end
endmodule : pwm_dac_channel
`default_nettype wire

// file: pwm_dac_pkg.sv
// constants, register map and pad carriers for the pwm dac period and pin select block
package pwm_dac_pkg;

   // -----------------------------------------------------------------------
   // register indices (byte address is four times the index)
   // -----------------------------------------------------------------------
   localparam logic [13:0] IDX_CHAN0_PULSE_WIDTH  = 14'h0F20;
   localparam logic [13:0] IDX_CHAN8_PULSE_WIDTH  = 14'h0F28;
   localparam logic [13:0] IDX_RESERVED_A         = 14'h0F29;
   localparam logic [13:0] IDX_RESERVED_B         = 14'h0F2A;
   localparam logic [13:0] IDX_CHAN01_PRESCALE    = 14'h0F2B;
   localparam logic [13:0] IDX_PAD_SELECT_ZERO    = 14'h0F50;
   localparam logic [13:0] IDX_PAD_SELECT_ONE     = 14'h0F51;
   localparam logic [13:0] IDX_PWM_OPTION         = 14'h0F56;

   // -----------------------------------------------------------------------
   // reset values
   // -----------------------------------------------------------------------
   localparam logic [7:0]  RST_PULSE_WIDTH        = 8'h80;
   localparam logic [7:0]  RST_PRESCALE           = 8'h00;
   localparam logic [7:0]  RST_PAD_SELECT         = 8'h00;
   localparam logic [1:0]  RST_OPTION             = 2'h0;

   // -----------------------------------------------------------------------
   // field positions
   // -----------------------------------------------------------------------
   localparam int          PAD0_CH8_ENABLE_BIT    = 0;
   localparam int          PAD0_SERIAL_REMAP_BIT  = 7;
   localparam int          OPT_DIVIDER_SEL_BIT    = 7;
   localparam int          OPT_REDUCED_STEP_BIT   = 6;
   localparam int          PRESCALE_CH0_LSB       = 0;
   localparam int          PRESCALE_CH1_LSB       = 4;

   // -----------------------------------------------------------------------
   // timing and resolution
   // -----------------------------------------------------------------------
   localparam int          BASE_DIV_FAST          = 512;
   localparam int          BASE_DIV_SLOW          = 1024;
   localparam int          STEPS_FULL             = 256;
   localparam int          STEPS_REDUCED          = 253;
   localparam logic [3:0]  MIN_SHIFT              = 4'h1;
   localparam logic [7:0]  HIGH_FLOOR             = 8'hFD;
   localparam int          NUM_CHAN               = 9;

   // -----------------------------------------------------------------------
   // pad carriers
   // -----------------------------------------------------------------------
   typedef struct packed {
      logic [8:0] o;
      logic [8:0] oe;
   } pwm_pad_s;

   typedef struct packed {
      logic [3:0] o;
      logic [3:0] oe;
   } serial_pad_s;

endpackage : pwm_dac_pkg

// file: pwm_dac_top.sv
// pwm dac channels with apb registers, period prescale and pad routing
//
// Notes on behaviour
// - channel 8 pulse width is a read/write byte, reset 0x80.
// - channel 0 period is clock period times two to the prescale low nibble.
// - channel 1 period is clock period times two to the prescale high nibble.
// - channels 0 and 1 never run a period below two clocks.
// - period prescale register resets to 0x00.
// - every channel starts at mid-scale 0x80 after reset.
// - pad select zero bit 0 puts channel 8 on its pin, else port bit.
// - pad select one bits 7..0 put channels 7..0 on their pins.
// - pad select zero bit 7 remaps four port pins to serial signals.
// - both pad select registers reset to 0x00, all pins port bits.
// - option bit selects base clock divide by 512 or by 1024.
// - option bit selects 253-step or 256-step resolution.
// - in 253-step mode values FD..FF hold the output high.
// - value 00 holds low; in 256-step mode FF still pulses low.
`timescale 1ns/1ps
`default_nettype none
module pwm_dac_top
   import pwm_dac_pkg::*;
#(
   parameter int DIV_FAST = BASE_DIV_FAST,
   parameter int DIV_SLOW = BASE_DIV_SLOW
) (
   // clock and reset
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   // apb slave
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [15:0]              paddr,
   input  wire logic [31:0]              pwdata,
   output logic                          pready,
   output logic [31:0]                   prdata,
   output logic                          pslverr,
   // port logic drive for the pwm capable pins
   input  wire pwm_dac_pkg::pwm_pad_s    port_pwm_drive,
   output pwm_dac_pkg::pwm_pad_s         pwm_pad,
   // port 7 pins 2 to 5 shared with serial
   input  wire pwm_dac_pkg::serial_pad_s port_serial_drive,
   input  wire pwm_dac_pkg::serial_pad_s spi_drive,
   input  wire logic [3:0]               serial_pin_i,
   output pwm_dac_pkg::serial_pad_s      serial_pad,
   output logic [3:0]                    port_serial_in,
   output logic [3:0]                    spi_in
);
   // -----------------------------------------------------------------------
   // register state
   // -----------------------------------------------------------------------
   logic [7:0]  width_q [NUM_CHAN];
   logic [7:0]  prescale_q;
   logic [7:0]  pad_zero_q;
   logic [7:0]  pad_one_q;
   logic [1:0]  option_q;
   // bus answer
   logic        pready_q;
   logic        pslverr_q;
   logic [31:0] prdata_q;

   // -----------------------------------------------------------------------
   // apb decode
   // -----------------------------------------------------------------------
   // word index
   logic [13:0] idx;
   logic        aligned;

   // per-word hits
   logic        hit_width;
   logic [3:0]  width_sel;
   logic        hit_reserved;
   logic        hit_prescale;
   logic        hit_pad_zero;
   logic        hit_pad_one;
   logic        hit_option;

   logic        mapped;
   logic        setup;
   logic        wr_en;
   logic [7:0]  rd_byte;

   // shared word compare
   function automatic logic is_idx(input logic [13:0] a, input logic [13:0] b);
      is_idx = (a == b);
   endfunction : is_idx

   assign idx          = paddr[15:2];
   assign aligned      = (paddr[1:0] == 2'b00);
   assign hit_width    = aligned && (idx >= IDX_CHAN0_PULSE_WIDTH) && (idx <= IDX_CHAN8_PULSE_WIDTH);
   assign width_sel    = 4'(idx - IDX_CHAN0_PULSE_WIDTH);
   // reserved words answer, no error
   assign hit_reserved = aligned && (is_idx(idx, IDX_RESERVED_A) || is_idx(idx, IDX_RESERVED_B));
   assign hit_prescale = aligned && is_idx(idx, IDX_CHAN01_PRESCALE);
   assign hit_pad_zero = aligned && is_idx(idx, IDX_PAD_SELECT_ZERO);
   assign hit_pad_one  = aligned && is_idx(idx, IDX_PAD_SELECT_ONE);
   assign hit_option   = aligned && is_idx(idx, IDX_PWM_OPTION);
   assign mapped       = hit_width || hit_reserved || hit_prescale || hit_pad_zero || hit_pad_one || hit_option;

   assign setup        = psel && !penable;
   // writes land only on the completing access edge
   assign wr_en        = psel && penable && pready_q && pwrite && mapped;

   // holes read zero
   assign rd_byte = hit_width    ? width_sel_read(width_sel) :
                    hit_prescale ? prescale_q :
                    hit_pad_zero ? {pad_zero_q[PAD0_SERIAL_REMAP_BIT], 6'h00, pad_zero_q[PAD0_CH8_ENABLE_BIT]} :
                    hit_pad_one  ? pad_one_q :
                    hit_option   ? {option_q, 6'h00} :
                                   8'h00;

   // bad select reads zero
   function automatic logic [7:0] width_sel_read(input logic [3:0] s);
      width_sel_read = 8'h00;
      for (int i = 0; i < NUM_CHAN; i++) begin
         if (s == 4'(i)) begin
            width_sel_read = width_q[i];
         end
      end
   endfunction : width_sel_read

   // zero wait states: answer registered in the setup cycle, ready for one access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup && !mapped;
         if (setup) begin
            prdata_q <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
         end
      end
   end

   // bus answer leaves from flops
   assign pready  = pready_q;
   assign pslverr = pslverr_q;
   assign prdata  = prdata_q;

   // -----------------------------------------------------------------------
   // register writes
   // -----------------------------------------------------------------------
   generate
      // one write decode per channel
      for (genvar c = 0; c < NUM_CHAN; c++) begin : g_width
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               width_q[c] <= RST_PULSE_WIDTH;
            end else if (wr_en && hit_width && (width_sel == 4'(c))) begin
               width_q[c] <= pwdata[7:0];
            end
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prescale_q <= RST_PRESCALE;
         pad_zero_q <= RST_PAD_SELECT;
         pad_one_q  <= RST_PAD_SELECT;
         option_q   <= RST_OPTION;
      end else begin
         if (wr_en && hit_prescale) begin
            prescale_q <= pwdata[7:0];
         end
         // only bits 7 and 0 exist
         if (wr_en && hit_pad_zero) begin
            pad_zero_q <= pwdata[7:0] & 8'h81;
         end
         if (wr_en && hit_pad_one) begin
            pad_one_q <= pwdata[7:0];
         end
         // applied at period end
         if (wr_en && hit_option) begin
            option_q <= {pwdata[OPT_DIVIDER_SEL_BIT], pwdata[OPT_REDUCED_STEP_BIT]};
         end
      end
   end

   // -----------------------------------------------------------------------
   // base step timing for channels 2 to 8
   // -----------------------------------------------------------------------
   // ratios stay multiples of 256
   localparam int          STEP_CLKS_FAST = DIV_FAST / STEPS_FULL;
   localparam int          STEP_CLKS_SLOW = DIV_SLOW / STEPS_FULL;
   localparam logic [9:0]  STEP_LAST_FAST = 10'(STEP_CLKS_FAST - 1);
   localparam logic [9:0]  STEP_LAST_SLOW = 10'(STEP_CLKS_SLOW - 1);
   // last step of each resolution
   localparam logic [7:0]  LAST_FULL      = 8'(STEPS_FULL - 1);
   localparam logic [7:0]  LAST_REDUCED   = 8'(STEPS_REDUCED - 1);

   logic [9:0] div_q;
   logic [7:0] step_q;
   logic       reduced_q;
   logic       fast_q;

   logic [9:0] div_last;
   logic       tick;
   logic [7:0] step_last;
   logic       base_wrap;

   // mode bits are taken at the period boundary so a running period stays whole
   assign div_last  = fast_q ? STEP_LAST_FAST : STEP_LAST_SLOW;
   assign tick      = (div_q == div_last);
   assign step_last = reduced_q ? LAST_REDUCED : LAST_FULL;
   assign base_wrap = tick && (step_q == step_last);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q     <= 10'h000;
         step_q    <= 8'h00;
         reduced_q <= 1'b0;
         fast_q    <= 1'b0;
      end else begin
         // shared step counter
         div_q <= tick ? 10'h000 : div_q + 10'h001;
         if (base_wrap) begin
            step_q    <= 8'h00;
            reduced_q <= option_q[0];
            fast_q    <= option_q[1];
         end else if (tick) begin
            step_q <= step_q + 8'h01;
         end
      end
   end

   // -----------------------------------------------------------------------
   // prescaled period counters for channels 0 and 1
   // -----------------------------------------------------------------------
   logic [8:0] chan_pwm;
   logic       fast_wrap  [2];

   generate
      for (genvar f = 0; f < 2; f++) begin : g_fast
         logic [14:0] pcnt_q;
         logic [3:0]  shift_q;
         logic [3:0]  shift_req;
         logic [14:0] pmask;
         localparam int LSB = (f == 0) ? PRESCALE_CH0_LSB : PRESCALE_CH1_LSB;

         // a zero exponent would give a one-clock period, so it is lifted to one
         assign shift_req = (prescale_q[LSB+3:LSB] < MIN_SHIFT) ? MIN_SHIFT
                                                                : prescale_q[LSB+3:LSB];
         assign pmask     = 15'((16'h0001 << shift_q) - 16'h0001);
         assign fast_wrap[f]  = (pcnt_q == pmask);

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pcnt_q  <= 15'h0000;
               shift_q <= MIN_SHIFT;
            // shift taken only at the wrap
            end else if (fast_wrap[f]) begin
               pcnt_q  <= 15'h0000;
               shift_q <= shift_req;
            end else begin
               pcnt_q <= pcnt_q + 15'h0001;
            end
         end

         // phase is pcnt times 256
         pwm_dac_channel u_chan (
            .pclk    (pclk),
            .presetn (presetn),
            .start   (fast_wrap[f]),
            .last    (fast_wrap[f]),
            .phase   ({1'b0, pcnt_q, 8'h00}),
            .shift   (shift_q),
            .reduced (reduced_q),
            .value   (width_q[f]),
            .pwm     (chan_pwm[f])
         );
      end

      // shared step timing
      for (genvar b = 2; b < NUM_CHAN; b++) begin : g_base
         pwm_dac_channel u_chan (
            .pclk    (pclk),
            .presetn (presetn),
            .start   (base_wrap),
            .last    (step_q == LAST_FULL),
            .phase   ({16'h0000, step_q}),
            .shift   (4'h0),
            .reduced (reduced_q),
            .value   (width_q[b]),
            .pwm     (chan_pwm[b])
         );
      end
   endgenerate

   // -----------------------------------------------------------------------
   // pad routing
   // -----------------------------------------------------------------------
   logic [8:0]  pin_enable;
   pwm_pad_s    pwm_pad_q;
   pwm_pad_s    pwm_pad_d;
   serial_pad_s serial_pad_q;
   serial_pad_s serial_pad_d;
   // serial remap and pin sync
   logic        remap;
   logic [3:0]  serial_meta_q;
   logic [3:0]  serial_sync_q;
   logic [3:0]  port_in_q;
   logic [3:0]  spi_in_q;

   // clear enable: port keeps pin
   assign pin_enable   = {pad_zero_q[PAD0_CH8_ENABLE_BIT], pad_one_q};
   assign pwm_pad_d.o  = (chan_pwm & pin_enable) | (port_pwm_drive.o & ~pin_enable);
   assign pwm_pad_d.oe = pin_enable | port_pwm_drive.oe;
   assign remap        = pad_zero_q[PAD0_SERIAL_REMAP_BIT];
   // all four pins swap together
   assign serial_pad_d = remap ? spi_drive : port_serial_drive;

   // pin inputs are asynchronous and pass two flops before use
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_pad_q     <= '0;
         serial_pad_q  <= '0;
         serial_meta_q <= 4'h0;
         serial_sync_q <= 4'h0;
         port_in_q     <= 4'h0;
         spi_in_q      <= 4'h0;
      end else begin
         pwm_pad_q     <= pwm_pad_d;
         serial_pad_q  <= serial_pad_d;
         serial_meta_q <= serial_pin_i;
         serial_sync_q <= serial_meta_q;
         port_in_q     <= remap ? 4'h0 : serial_sync_q;
         spi_in_q      <= remap ? serial_sync_q : 4'h0;
      end
   end

   // pads leave straight from flops
   assign pwm_pad        = pwm_pad_q;
   assign serial_pad     = serial_pad_q;
   assign port_serial_in = port_in_q;
   assign spi_in         = spi_in_q;

endmodule : pwm_dac_top
`default_nettype wire

// file: pwm_dac_top_props.sv
// concurrent checks on the ports of the pwm dac top
`timescale 1ns/1ps
`default_nettype none
module pwm_dac_top_props
#(
   parameter int DIV_FAST = 512,
   parameter int DIV_SLOW = 1024
) (
   // clock and reset
   input wire logic                     pclk,
   input wire logic                     presetn,
   // apb
   input wire logic                     psel,
   input wire logic                     penable,
   input wire logic                     pwrite,
   input wire logic [15:0]              paddr,
   input wire logic [31:0]              pwdata,
   input wire logic                     pready,
   input wire logic [31:0]              prdata,
   input wire logic                     pslverr,
   // pads
   input wire pwm_dac_pkg::pwm_pad_s    port_pwm_drive,
   input wire pwm_dac_pkg::pwm_pad_s    pwm_pad,
   input wire pwm_dac_pkg::serial_pad_s port_serial_drive,
   input wire pwm_dac_pkg::serial_pad_s spi_drive,
   input wire logic [3:0]               serial_pin_i,
   input wire pwm_dac_pkg::serial_pad_s serial_pad,
   input wire logic [3:0]               port_serial_in,
   input wire logic [3:0]               spi_in
);
   import pwm_dac_pkg::*;
   // -----------------------------------------------------------------------
   // apb timing
   // -----------------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   a_setup_gets_ready: assert property (s_setup |=> pready && psel && penable)
      else $error("no ready in first access cycle");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready stood longer than one cycle");
   a_misalign_err: assert property (s_setup ##0 (paddr[1:0] != 2'h0) |=> pslverr)
      else $error("misaligned access not refused");
   a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returned data");
   // -----------------------------------------------------------------------
   // pad routing: a pwm pad only leaves the port drive to carry a pwm output, a serial pad to carry spi
   // -----------------------------------------------------------------------
   a_pad_oe_keep: assert property ($past(presetn) |->
      (pwm_pad.oe & $past(port_pwm_drive.oe)) == $past(port_pwm_drive.oe))
      else $error("pad enable dropped below port drive");
   a_pad_o_keep: assert property ($past(presetn) |->
      ((pwm_pad.o ^ $past(port_pwm_drive.o)) & ~pwm_pad.oe) == 9'h000)
      else $error("undriven pad level differs from port");
   a_serial_route: assert property (serial_pad == $past(port_serial_drive) || serial_pad == $past(spi_drive))
      else $error("serial pad from neither source");
   a_in_exclusive: assert property (port_serial_in == 4'h0 || spi_in == 4'h0)
      else $error("both serial input paths active");
endmodule : pwm_dac_top_props
`default_nettype wire

// file: tb_pwm_dac_period_and_pin_select.sv
// self-checking testbench for the pwm dac period and pin select block
`timescale 1ns/1ps
`default_nettype none
module tb_pwm_dac_period_and_pin_select;
   import pwm_dac_pkg::*;
   logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [15:0]       paddr;
   logic [31:0]       pwdata, prdata, rd;
   logic              err;
   pwm_pad_s          port_pwm_drive, pwm_pad;
   serial_pad_s       port_serial_drive, spi_drive, serial_pad;
   logic [3:0]        serial_pin_i, port_serial_in, spi_in, ext_oe, ext_o;
   logic [8:0]        pin_level;
   int                num_errors, cmp_count, cyc, hi;
   logic [7:0]        pre;
   pwm_dac_top #(.DIV_FAST(512), .DIV_SLOW(1024)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .port_pwm_drive(port_pwm_drive), .pwm_pad(pwm_pad),
      .port_serial_drive(port_serial_drive), .spi_drive(spi_drive), .serial_pin_i(serial_pin_i),
      .serial_pad(serial_pad), .port_serial_in(port_serial_in), .spi_in(spi_in));
   pin_load_model load (.pwm_pad(pwm_pad), .serial_pad(serial_pad), .ext_oe(ext_oe), .ext_o(ext_o),
      .pin_level(pin_level), .serial_level(serial_pin_i));
   // -----------------------------------------------------------------------
   // tasks
   // -----------------------------------------------------------------------
   task automatic stop_test();
      if (num_errors == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : stop_test
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   function automatic logic [15:0] ad(input logic [13:0] idx);
      return {idx, 2'b00};
   endfunction : ad
   task automatic apb(input logic wr, input logic [15:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
         check(32'h0, 32'h1);
   endtask : apb
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp, input logic experr);
      apb(1'b0, a, 8'h00);
      check(rd, {24'h0, exp});
      check({31'h0, err}, {31'h0, experr});
   endtask : rd_chk
   // cycles from the call to the next rising edge of a pwm pin
   task automatic to_rise(input int ch, output int n);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pin_level[ch] !== 1'b0 && n < 3000);
      do begin
         @(posedge pclk);
         n++;
      end while (pin_level[ch] !== 1'b1 && n < 3000);
   endtask : to_rise
   // the first rise may still belong to the old setting, so measure the third
   task automatic period(input int ch, input int exp);
      int n;
      repeat (3) to_rise(ch, n);
      check(n, exp);
   endtask : period
   task automatic count_high(input int ch, input int len);
      hi = 0;
      repeat (len) begin
         @(posedge pclk);
         hi += int'(pin_level[ch] === 1'b1);
      end
   endtask : count_high
   // -----------------------------------------------------------------------
   // clock, reset and timeout
   // -----------------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 40000) begin
         num_errors++;
         stop_test();
      end
   end
   // -----------------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------------
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 16'h0000;
      pwdata = 32'h0;
      port_pwm_drive = {9'h155, 9'h0F0};
      port_serial_drive = {4'h0, 4'h0};
      spi_drive = {4'b1001, 4'b1011};
      ext_oe = 4'b0100;
      ext_o = 4'b0000;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 9; i++)
         rd_chk(ad(IDX_CHAN0_PULSE_WIDTH + 14'(i)), 8'h80, 1'b0);
      rd_chk(ad(IDX_CHAN01_PRESCALE), 8'h00, 1'b0);
      rd_chk(ad(IDX_PAD_SELECT_ZERO), 8'h00, 1'b0);
      rd_chk(ad(IDX_PAD_SELECT_ONE), 8'h00, 1'b0);
      check(pwm_pad, port_pwm_drive);
      check(serial_pad, port_serial_drive);
      check(port_serial_in, 4'hB);
      check(spi_in, 4'h0);
      apb(1'b1, ad(IDX_CHAN8_PULSE_WIDTH), 8'h5A);
      apb(1'b1, ad(IDX_CHAN8_PULSE_WIDTH) | 16'h2, 8'h11);
      rd_chk(ad(IDX_CHAN8_PULSE_WIDTH), 8'h5A, 1'b0);
      rd_chk(ad(IDX_CHAN8_PULSE_WIDTH) | 16'h2, 8'h00, 1'b1);
      rd_chk(16'h0004, 8'h00, 1'b1);
      rd_chk(ad(IDX_RESERVED_A), 8'h00, 1'b0);
      apb(1'b1, ad(IDX_PAD_SELECT_ZERO), 8'h01);
      rd_chk(ad(IDX_PAD_SELECT_ZERO), 8'h01, 1'b0);
      repeat (4) @(posedge pclk);
      check(pwm_pad.oe, port_pwm_drive.oe | 9'h100);
      apb(1'b1, ad(IDX_PAD_SELECT_ZERO), 8'h80);
      repeat (6) @(posedge pclk);
      check(pwm_pad, port_pwm_drive);
      check(serial_pad, spi_drive);
      check(spi_in, 4'h9);
      check(port_serial_in, 4'h0);
      apb(1'b1, ad(IDX_PAD_SELECT_ONE), 8'h07);
      rd_chk(ad(IDX_PAD_SELECT_ONE), 8'h07, 1'b0);
      check(pwm_pad.oe, port_pwm_drive.oe | 9'h007);
      for (int i = 0; i < 3; i++) begin
         pre = (i == 0) ? 8'h53 : (i == 1) ? 8'h00 : 8'h14;
         apb(1'b1, ad(IDX_CHAN01_PRESCALE), pre);
         period(0, 1 << ((pre[3:0] == 4'h0) ? 1 : pre[3:0]));
         period(1, 1 << ((pre[7:4] == 4'h0) ? 1 : pre[7:4]));
      end
      rd_chk(ad(IDX_CHAN01_PRESCALE), 8'h14, 1'b0);
      period(2, 1024);
      apb(1'b1, ad(IDX_PWM_OPTION), 8'h80);
      period(2, 512);
      apb(1'b1, ad(IDX_PWM_OPTION), 8'hC0);
      period(2, 506);
      apb(1'b1, ad(IDX_CHAN0_PULSE_WIDTH + 14'h2), 8'h00);
      repeat (600) @(posedge pclk);
      count_high(2, 520);
      check(hi, 0);
      for (int v = 253; v < 256; v++) begin
         apb(1'b1, ad(IDX_CHAN0_PULSE_WIDTH + 14'h2), 8'(v));
         repeat (600) @(posedge pclk);
         count_high(2, 520);
         check(hi, 520);
      end
      apb(1'b1, ad(IDX_PWM_OPTION), 8'h80);
      repeat (600) @(posedge pclk);
      count_high(2, 520);
      check(hi > 0 && hi < 520, 1);
      stop_test();
   end
endmodule : tb_pwm_dac_period_and_pin_select
bind pwm_dac_top pwm_dac_top_props #(.DIV_FAST(DIV_FAST), .DIV_SLOW(DIV_SLOW)) props (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pready(pready), .prdata(prdata), .pslverr(pslverr), .port_pwm_drive(port_pwm_drive), .pwm_pad(pwm_pad),
   .port_serial_drive(port_serial_drive), .spi_drive(spi_drive), .serial_pin_i(serial_pin_i),
   .serial_pad(serial_pad), .port_serial_in(port_serial_in), .spi_in(spi_in));
`default_nettype wire
